// [rtl/qtu_pkg.sv]
// Purpose: Constants for the quad 8-bit timer unit
// Assumes: Register indices are word indices; byte address is index times four
// Notes:   Reserved bits of every register read as zero
package qtu_pkg;

  localparam int unsigned NUM_TIMERS = 4;
  localparam int unsigned CNT_W      = 8;
  localparam int unsigned NIB_W      = 4;
  localparam int unsigned IDX_W      = 8;
  localparam int unsigned ADR_W      = 10;
  localparam int unsigned DAT_W      = 32;

  // Word indices, timer 3 first in each packed list
  localparam logic [3:0][7:0] IDX_DATA_LO = {8'h78, 8'h76, 8'h6a, 8'h68};
  localparam logic [3:0][7:0] IDX_DATA_HI = {8'h79, 8'h77, 8'h6b, 8'h69};
  localparam logic [3:0][7:0] IDX_CNT_LO  = {8'h7c, 8'h7a, 8'h6e, 8'h6c};
  localparam logic [3:0][7:0] IDX_CNT_HI  = {8'h7d, 8'h7b, 8'h6f, 8'h6d};
  localparam logic [3:0][7:0] IDX_CTL0    = {8'h80, 8'h7e, 8'h72, 8'h70};
  localparam logic [3:0][7:0] IDX_CTL1    = {8'h81, 8'h7f, 8'h73, 8'h71};
  localparam logic [3:0][7:0] IDX_STAT    = {8'h83, 8'h82, 8'h75, 8'h74};

  // Writable bits of the mode and clock control registers
  localparam logic [3:0][3:0] CTL0_MASK = {4'h1, 4'h5, 4'h3, 4'h7};
  localparam logic [3:0]      CTL1_MASK = 4'h3;

  localparam int unsigned CTL0_FMEAS_BIT = 2;
  localparam int unsigned CTL0_ECAP_BIT  = 1;
  localparam int unsigned CTL0_RUN_BIT   = 0;
  localparam int unsigned STAT_CAP_BIT   = 1;
  localparam int unsigned STAT_OVF_BIT   = 0;

  localparam logic [1:0] CLK_SLOW = 2'h0;
  localparam logic [1:0] CLK_FAST = 2'h1;
  localparam logic [1:0] CLK_EXT  = 2'h2;
  localparam logic [1:0] CLK_CASC = 2'h3;

  localparam logic [7:0] CNT_ALL_ONES = 8'hff;
  localparam logic [7:0] CNT_ZERO     = 8'h00;

endpackage : qtu_pkg

// [rtl/qtu_timer.sv]
// Purpose: Four 8-bit timers with 16-bit cascade, on a classic Wishbone slave
// Assumes: Clock sources are slow versus clk and are sampled by synchronisers
// Notes:   Every access is acknowledged one cycle after it is taken
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps

// Overview of operation
// [RULE1] Four independent 8-bit timers; pairs 0+1 and 2+3 cascade to 16 bits.
// [RULE2] In cascade, timer 0 overflow clocks timer 1, timer 2 overflow clocks timer 3.
// [RULE3] Timers 0 and 1 offer reload and capture, timers 0 and 2 frequency; timers 2 and 3 no capture.
// [RULE4] Count clock is slow base clock, fast clock or external pin.
// [RULE5] In auto-reload mode the data register holds the reload value.
// [RULE6] In capture mode the data register holds the captured count.
// [RULE7] Writing a data register copies the present counter into it.
// [RULE8] Writing a counter register writes the data register too, never the reverse.
// [RULE9] Counter is 8-bit binary, read as low and high nibbles.
// [RULE10] Reset clears all data, counter and control bits.
// [RULE11] Timer 0 mode code: 000,001 reload, 010,011 capture, 100 frequency.
// [RULE12] Timer 0 clock code: 00 slow, 01 fast, 10 external, 11 unused.
// [RULE13] Software waits 10 ms or 300 us after fast oscillator start.
// [RULE14] Software programs timer 1 controls to run the 0+1 cascade.
// [RULE15] Each timer has a read-only overflow bit toggling per overflow.
// [RULE16] Capture sets a flag blocking more captures; status read clears it.
// [RULE17] Timer 1 clock code 11 selects timer 0 overflow.
// [RULE18] Timer 1 mode code: 00 stop or cascade, 01 reload, 10,11 capture.
// [RULE19] Running counter past all-ones overflows and reloads in the same edge.
// [RULE20] Asynchronous clock sources are synchronised before driving counters.
module qtu_timer (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [qtu_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [qtu_pkg::DAT_W-1:0] wb_dat_i,
  output logic      [qtu_pkg::DAT_W-1:0] wb_dat_o,
  output logic                           wb_ack_o,
  input  wire logic                      slowBaseClock,
  input  wire logic                      fastClock,
  input  wire logic                      extCountPinA,
  input  wire logic                      extCountPinB,
  input  wire logic [1:0]                capturePin,
  output logic      [3:0]                overflowToggleFlag
);

  typedef struct packed {
    logic [3:0][7:0] cnt;
    logic [3:0][7:0] dat;
    logic [3:0][3:0] ctl0;
    logic [3:0][3:0] ctl1;
    logic [3:0]      ovf;
    logic [1:0]      cap;
    logic [2:0]      slowSync;
    logic [2:0]      fastSync;
    logic [2:0]      extASync;
    logic [2:0]      extBSync;
    logic [1:0][2:0] capSync;
    logic            ack;
    logic [31:0]     rdat;
  } qtu_state_t;

  qtu_state_t      state_q;
  qtu_state_t      state_d;
  logic [3:0]      tick;
  logic [3:0]      ovfEv;
  logic [1:0]      capEv;
  logic [3:0]      active;
  logic [3:0]      capMode;
  logic [3:0]      runBit;
  logic [3:0]      srcEdge;
  logic            take;
  logic            wr;
  logic            rd;
  logic [7:0]      idx;
  logic [3:0]      wd;
  logic            casc01;
  logic            casc23;
  logic [1:0]      capEdge;

  always_comb begin
    state_d = state_q;
    take    = wb_cyc_i && wb_stb_i && !state_q.ack;
    wr      = take && wb_we_i && wb_sel_i[0];
    rd      = take && !wb_we_i;
    idx     = wb_adr_i[qtu_pkg::ADR_W-1:2];
    wd      = wb_dat_i[3:0];
    // Stage one only feeds stage two; edges use stages two and three
    state_d.slowSync = {state_q.slowSync[1:0], slowBaseClock};  // [RULE20]
    state_d.fastSync = {state_q.fastSync[1:0], fastClock};      // [RULE20]
    state_d.extASync = {state_q.extASync[1:0], extCountPinA};   // [RULE20]
    state_d.extBSync = {state_q.extBSync[1:0], extCountPinB};   // [RULE20]
    for (int c = 0; c < 2; c++) begin
      state_d.capSync[c] = {state_q.capSync[c][1:0], capturePin[c]};
      capEdge[c] = state_q.capSync[c][2] ^ state_q.capSync[c][1];
    end
    casc01 = state_q.ctl1[1][1:0] == qtu_pkg::CLK_CASC;         // [RULE14] [RULE17]
    casc23 = state_q.ctl1[3][1:0] == qtu_pkg::CLK_CASC;
    tick    = '0;
    ovfEv   = '0;
    capEv   = '0;
    active  = '0;
    capMode = '0;
    runBit  = '0;
    srcEdge = '0;
    for (int k = 0; k < 4; k++) begin
      logic [3:0] c0;
      c0 = state_q.ctl0[k];
      // A cascaded low timer is governed by its partner's mode bits
      if (k == 0 && casc01) begin
        c0 = state_q.ctl0[1];
      end else if (k == 2 && casc23) begin
        c0 = state_q.ctl0[3];
      end
      runBit[k]  = c0[qtu_pkg::CTL0_RUN_BIT];
      // Unused codes with the frequency bit set leave the timer stopped
      capMode[k] = !c0[qtu_pkg::CTL0_FMEAS_BIT] && c0[qtu_pkg::CTL0_ECAP_BIT] && (k < 2);  // [RULE3]
      active[k]  = c0[qtu_pkg::CTL0_FMEAS_BIT] ? (c0[1:0] == 2'h0) : runBit[k];          // [RULE11] [RULE18]
      unique case (state_q.ctl1[k][1:0])                                                  // [RULE4] [RULE12]
        qtu_pkg::CLK_SLOW: srcEdge[k] = state_q.slowSync[1] && !state_q.slowSync[2];
        qtu_pkg::CLK_FAST: srcEdge[k] = state_q.fastSync[1] && !state_q.fastSync[2];
        qtu_pkg::CLK_EXT:  srcEdge[k] = (k % 2 == 0) ? (state_q.extASync[1] && !state_q.extASync[2])
                                                     : (state_q.extBSync[1] && !state_q.extBSync[2]);
        qtu_pkg::CLK_CASC: srcEdge[k] = (k == 1) ? ovfEv[0] : ((k == 3) ? ovfEv[2] : 1'b0); // [RULE2]
      endcase
      // The high half of a cascade follows the low half's run state
      if ((k == 1 && casc01) || (k == 3 && casc23)) begin
        tick[k] = srcEdge[k];                                                              // [RULE1]
      end else begin
        tick[k] = active[k] && srcEdge[k];
      end
      ovfEv[k] = tick[k] && (state_q.cnt[k] == qtu_pkg::CNT_ALL_ONES);
      if (tick[k]) begin
        if (ovfEv[k]) begin
          // Capture mode wraps; the data register holds a captured value there
          state_d.cnt[k] = capMode[k] ? qtu_pkg::CNT_ZERO : state_q.dat[k];               // [RULE5] [RULE19]
          state_d.ovf[k] = !state_q.ovf[k];                                                // [RULE15]
        end else begin
          state_d.cnt[k] = 8'(state_q.cnt[k] + 8'h01);                                     // [RULE9]
        end
      end
    end
    // Status read clears first so a simultaneous capture still sets the flag
    for (int k = 0; k < 2; k++) begin
      if (rd && idx == qtu_pkg::IDX_STAT[k]) begin
        state_d.cap[k] = 1'b0;                                                             // [RULE16]
      end
    end
    capEv[0] = capMode[0] && runBit[0] && capEdge[0] && !state_q.cap[0];
    capEv[1] = casc01 ? capEv[0] : (capMode[1] && runBit[1] && capEdge[1] && !state_q.cap[1]);
    for (int k = 0; k < 2; k++) begin
      if (capEv[k]) begin
        state_d.dat[k] = state_q.cnt[k];                                                   // [RULE6]
        state_d.cap[k] = 1'b1;                                                             // [RULE16]
      end
    end
    // Software writes win over counting in the same cycle
    for (int k = 0; k < 4; k++) begin
      if (wr && (idx == qtu_pkg::IDX_DATA_LO[k] || idx == qtu_pkg::IDX_DATA_HI[k])) begin
        state_d.dat[k] = state_q.cnt[k];                                                   // [RULE7]
      end
      if (wr && idx == qtu_pkg::IDX_CNT_LO[k]) begin
        state_d.cnt[k][3:0] = wd;                                                          // [RULE8]
        state_d.dat[k][3:0] = wd;
      end
      if (wr && idx == qtu_pkg::IDX_CNT_HI[k]) begin
        state_d.cnt[k][7:4] = wd;                                                          // [RULE8]
        state_d.dat[k][7:4] = wd;
      end
      if (wr && idx == qtu_pkg::IDX_CTL0[k]) begin
        state_d.ctl0[k] = wd & qtu_pkg::CTL0_MASK[k];
      end
      if (wr && idx == qtu_pkg::IDX_CTL1[k]) begin
        state_d.ctl1[k] = wd & qtu_pkg::CTL1_MASK;
      end
    end
    state_d.ack  = take;
    state_d.rdat = '0;
    if (rd) begin
      for (int k = 0; k < 4; k++) begin
        if (idx == qtu_pkg::IDX_DATA_LO[k]) state_d.rdat[3:0] = state_q.dat[k][3:0];
        if (idx == qtu_pkg::IDX_DATA_HI[k]) state_d.rdat[3:0] = state_q.dat[k][7:4];
        if (idx == qtu_pkg::IDX_CNT_LO[k])  state_d.rdat[3:0] = state_q.cnt[k][3:0];     // [RULE9]
        if (idx == qtu_pkg::IDX_CNT_HI[k])  state_d.rdat[3:0] = state_q.cnt[k][7:4];     // [RULE9]
        if (idx == qtu_pkg::IDX_CTL0[k])    state_d.rdat[3:0] = state_q.ctl0[k];
        if (idx == qtu_pkg::IDX_CTL1[k])    state_d.rdat[3:0] = state_q.ctl1[k];
        if (idx == qtu_pkg::IDX_STAT[k]) begin
          state_d.rdat[qtu_pkg::STAT_OVF_BIT] = state_q.ovf[k];
          state_d.rdat[qtu_pkg::STAT_CAP_BIT] = (k < 2) ? state_q.cap[k % 2] : 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= '0;                                                                       // [RULE10]
    end else begin
      state_q <= state_d;
    end
  end

  assign wb_ack_o           = state_q.ack;
  assign wb_dat_o           = state_q.rdat;
  assign overflowToggleFlag = state_q.ovf;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic wrCnt0Lo;
  logic wrData0;
  logic wr2Any;
  assign wrCnt0Lo = wr && idx == qtu_pkg::IDX_CNT_LO[0];
  assign wrData0  = wr && (idx == qtu_pkg::IDX_DATA_LO[0] || idx == qtu_pkg::IDX_DATA_HI[0]);
  assign wr2Any   = wr && (idx == qtu_pkg::IDX_CNT_LO[2] || idx == qtu_pkg::IDX_CNT_HI[2]
                           || idx == qtu_pkg::IDX_DATA_LO[2] || idx == qtu_pkg::IDX_DATA_HI[2]);

  sequence s_reloadEdge;
    tick[0] && !capMode[0] && state_q.cnt[0] == qtu_pkg::CNT_ALL_ONES && !wr;
  endsequence
  sequence s_reloadDone;
    state_q.cnt[0] == $past(state_q.dat[0]) && state_q.ovf[0] != $past(state_q.ovf[0]);
  endsequence

  property p_ackOnce;
    take |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ackOnce: assert property (p_ackOnce) else $error("ack not a single pulse");  // [RULE1]

  property p_cascade01;
    casc01 && ovfEv[0] |-> tick[1];
  endproperty
  a_cascade01: assert property (p_cascade01) else $error("timer 1 missed timer 0 overflow");  // [RULE2]

  property p_noCapture2;
    !wr2Any |=> $stable(state_q.dat[2]);
  endproperty
  a_noCapture2: assert property (p_noCapture2) else $error("timer 2 data changed without write");  // [RULE3]

  property p_slowSource;
    tick[0] && state_q.ctl1[0][1:0] == qtu_pkg::CLK_SLOW |-> state_q.slowSync[1] && !state_q.slowSync[2];
  endproperty
  a_slowSource: assert property (p_slowSource) else $error("slow tick without slow edge");  // [RULE4]

  property p_reload;
    s_reloadEdge |=> s_reloadDone;
  endproperty
  a_reload: assert property (p_reload) else $error("reload or overflow toggle missing");  // [RULE19]

  property p_reloadHold;
    !capMode[0] && !wrData0 && !wrCnt0Lo && !(wr && idx == qtu_pkg::IDX_CNT_HI[0]) |=> $stable(state_q.dat[0]);
  endproperty
  a_reloadHold: assert property (p_reloadHold) else $error("reload value changed");  // [RULE5]

  property p_capture;
    capEv[0] && !wr |=> state_q.dat[0] == $past(state_q.cnt[0]) && state_q.cap[0];
  endproperty
  a_capture: assert property (p_capture) else $error("capture data or flag wrong");  // [RULE6]

  property p_dataWrite;
    wrData0 |=> state_q.dat[0] == $past(state_q.cnt[0]);
  endproperty
  a_dataWrite: assert property (p_dataWrite) else $error("data write did not copy counter");  // [RULE7]

  property p_countWrite;
    wrCnt0Lo |=> state_q.cnt[0][3:0] == $past(wd) && state_q.dat[0][3:0] == $past(wd);
  endproperty
  a_countWrite: assert property (p_countWrite) else $error("counter write not mirrored");  // [RULE8]

  property p_nibbleRead;
    rd && idx == qtu_pkg::IDX_CNT_HI[0] |=> wb_dat_o == {28'h0000000, $past(state_q.cnt[0][7:4])};
  endproperty
  a_nibbleRead: assert property (p_nibbleRead) else $error("counter high nibble read wrong");  // [RULE9]

  property p_resetClear;
    !$past(nrst) |-> state_q.cnt == '0 && state_q.dat == '0 && state_q.ctl0 == '0 && state_q.ctl1 == '0;
  endproperty
  a_resetClear: assert property (p_resetClear) else $error("registers not clear after reset");  // [RULE10]

  property p_freqCount;
    state_q.ctl0[0][2:0] == 3'h4 && !casc01 && tick[0] && state_q.cnt[0] != qtu_pkg::CNT_ALL_ONES && !wr
      |=> state_q.cnt[0] == 8'($past(state_q.cnt[0]) + 8'h01);
  endproperty
  a_freqCount: assert property (p_freqCount) else $error("frequency mode did not count");  // [RULE11]

  property p_unusedClock;
    state_q.ctl1[0][1:0] == qtu_pkg::CLK_CASC |-> !tick[0];
  endproperty
  a_unusedClock: assert property (p_unusedClock) else $error("timer 0 counted on unused clock");  // [RULE12]

  property p_ovfToggle;
    $changed(state_q.ovf[0]) |-> $past(ovfEv[0]);
  endproperty
  a_ovfToggle: assert property (p_ovfToggle) else $error("overflow bit toggled without overflow");  // [RULE15]

  property p_captureBlock;
    state_q.cap[0] && !(rd && idx == qtu_pkg::IDX_STAT[0]) && !wr |=> $stable(state_q.dat[0]) && state_q.cap[0];
  endproperty
  a_captureBlock: assert property (p_captureBlock) else $error("capture not blocked by flag");  // [RULE16]

  property p_cascadeOnly;
    casc01 && !ovfEv[0] |-> !tick[1];
  endproperty
  a_cascadeOnly: assert property (p_cascadeOnly) else $error("cascaded timer 1 ticked alone");  // [RULE17]

  property p_t1Stopped;
    state_q.ctl0[1][1:0] == 2'h0 && !casc01 && !wr |=> $stable(state_q.cnt[1]);
  endproperty
  a_t1Stopped: assert property (p_t1Stopped) else $error("stopped timer 1 counted");  // [RULE18]

  property p_syncFast;
    tick[2] && state_q.ctl1[2][1:0] == qtu_pkg::CLK_FAST |-> state_q.fastSync[1] && !state_q.fastSync[2];
  endproperty
  a_syncFast: assert property (p_syncFast) else $error("fast tick not from synchronised edge");  // [RULE20]

  property p_cascade23;
    casc23 && ovfEv[2] && state_q.cnt[3] != qtu_pkg::CNT_ALL_ONES && !wr
      |=> state_q.cnt[3] == 8'($past(state_q.cnt[3]) + 8'h01);
  endproperty
  a_cascade23: assert property (p_cascade23) else $error("timer 3 did not count timer 2 overflow");  // [RULE2]

  property p_noCapFlag2;
    rd && idx == qtu_pkg::IDX_STAT[2] |=> !wb_dat_o[qtu_pkg::STAT_CAP_BIT];
  endproperty
  a_noCapFlag2: assert property (p_noCapFlag2) else $error("timer 2 reported a capture");  // [RULE3]

  property p_reload3;
    tick[3] && state_q.cnt[3] == qtu_pkg::CNT_ALL_ONES && !wr |=> state_q.cnt[3] == $past(state_q.dat[3]);
  endproperty
  a_reload3: assert property (p_reload3) else $error("timer 3 did not reload");  // [RULE5]

  property p_capture1;
    capEv[1] && !wr |=> state_q.dat[1] == $past(state_q.cnt[1]) && state_q.cap[1];
  endproperty
  a_capture1: assert property (p_capture1) else $error("timer 1 capture data or flag wrong");  // [RULE6]

  property p_captureWrap;
    capMode[0] && tick[0] && state_q.cnt[0] == qtu_pkg::CNT_ALL_ONES && !wr
      |=> state_q.cnt[0] == qtu_pkg::CNT_ZERO;
  endproperty
  a_captureWrap: assert property (p_captureWrap) else $error("capture mode counter did not wrap");  // [RULE6]

  property p_stopped0;
    state_q.ctl0[0][2:0] == 3'h0 && !casc01 && !wr |=> $stable(state_q.cnt[0]);
  endproperty
  a_stopped0: assert property (p_stopped0) else $error("stopped timer 0 counted");  // [RULE11]

  property p_unusedMode;
    !casc01 && state_q.ctl0[0][qtu_pkg::CTL0_FMEAS_BIT] && state_q.ctl0[0][1:0] != 2'h0 |-> !tick[0];
  endproperty
  a_unusedMode: assert property (p_unusedMode) else $error("timer 0 counted in unused mode");  // [RULE11]

  property p_ovfToggle2;
    $changed(state_q.ovf[2]) |-> $past(ovfEv[2]);
  endproperty
  a_ovfToggle2: assert property (p_ovfToggle2) else $error("timer 2 overflow bit toggled alone");  // [RULE15]

  property p_statusRead1;
    rd && idx == qtu_pkg::IDX_STAT[1] |=> wb_dat_o == {30'h00000000, $past(state_q.cap[1]), $past(state_q.ovf[1])};
  endproperty
  a_statusRead1: assert property (p_statusRead1) else $error("timer 1 status read wrong");  // [RULE15]

  property p_capClear;
    rd && idx == qtu_pkg::IDX_STAT[0] && !capEv[0] |=> !state_q.cap[0];
  endproperty
  a_capClear: assert property (p_capClear) else $error("status read left capture flag set");  // [RULE16]

  property p_countWriteHi;
    wr && idx == qtu_pkg::IDX_CNT_HI[0] |=> state_q.cnt[0][7:4] == $past(wd) && state_q.dat[0][7:4] == $past(wd);
  endproperty
  a_countWriteHi: assert property (p_countWriteHi) else $error("counter high write not mirrored");  // [RULE8]

  property p_dataKeepsCount;
    wrData0 && !tick[0] |=> $stable(state_q.cnt[0]);
  endproperty
  a_dataKeepsCount: assert property (p_dataKeepsCount) else $error("data write altered counter");  // [RULE8]

endmodule : qtu_timer

// [verif/qtu_timer_test.sv]
// Purpose: Self-checking bench for the quad 8-bit timer unit
// Assumes: Count pins held four clocks so the input synchronisers catch every edge
// Notes:   Random counter values come from a fixed-seed shift register
`timescale 1ns/1ps
module qtu_timer_test;
  logic        clk;
  logic        nrst;
  logic        wbCyc;
  logic        wbStb;
  logic        wbWe;
  logic [9:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatW;
  logic [31:0] wbDatR;
  logic        wbAck;
  logic [3:0]  cntPins;
  logic [1:0]  capPins;
  logic [3:0]  ovfFlags;
  logic [3:0]  expOvf;
  logic [31:0] seed;
  logic [31:0] rdData;
  logic [7:0]  v;
  int          failCount;
  int          testsRun;

  qtu_timer DUT (.clk(clk), .nrst(nrst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .slowBaseClock(cntPins[0]),
    .fastClock(cntPins[1]), .extCountPinA(cntPins[2]), .extCountPinB(cntPins[3]), .capturePin(capPins),
    .overflowToggleFlag(ovfFlags));

  always #4 clk = ~clk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // Expected count after one tick of a reloading timer
  function automatic logic [7:0] next_count(input logic [7:0] cur, input logic [7:0] rel);
    return (cur == 8'hff) ? rel : 8'(cur + 8'h01);
  endfunction : next_count

  task automatic finishTest();
    $display("Checks run: %0d, mismatches: %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finishTest

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      failCount++;
    end
  endtask : check

  // Holds the request until ack is sampled high, then releases it
  task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [3:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= {idx, 2'b00};
    wbSel  <= 4'hf;
    wbDatW <= {28'h0, wd};
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 40);
    if (n >= 40) begin
      $display("unexpected at %0t: no bus acknowledge", $time);
      failCount++;
    end
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
  endtask : wb_xfer

  task automatic wr(input logic [7:0] idx, input logic [3:0] wd);
    logic [31:0] dummy;
    wb_xfer(1'b1, idx, wd, dummy);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [3:0] exp);
    logic [31:0] r;
    wb_xfer(1'b0, idx, 4'h0, r);
    check(r, {28'h0, exp});
  endtask : rd_chk

  task automatic set_cnt(input int t, input logic [7:0] val);
    wr(qtu_pkg::IDX_CNT_LO[t], val[3:0]);
    wr(qtu_pkg::IDX_CNT_HI[t], val[7:4]);
  endtask : set_cnt

  task automatic chk_cnt(input int t, input logic [7:0] val);
    rd_chk(qtu_pkg::IDX_CNT_LO[t], val[3:0]);
    rd_chk(qtu_pkg::IDX_CNT_HI[t], val[7:4]);
  endtask : chk_cnt

  task automatic chk_data(input int t, input logic [7:0] val);
    rd_chk(qtu_pkg::IDX_DATA_LO[t], val[3:0]);
    rd_chk(qtu_pkg::IDX_DATA_HI[t], val[7:4]);
  endtask : chk_data

  task automatic set_ctl(input int t, input logic [3:0] mode, input logic [3:0] src);
    wr(qtu_pkg::IDX_CTL1[t], src);
    wr(qtu_pkg::IDX_CTL0[t], mode);
  endtask : set_ctl

  // Slow pulse so the three-flop synchroniser path settles before the next access
  task automatic pulse(input int p);
    @(posedge clk);
    cntPins[p] <= 1'b1;
    repeat (4) @(posedge clk);
    cntPins[p] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pulse

  task automatic cap_edge(input int t);
    @(posedge clk);
    capPins[t] <= ~capPins[t];
    repeat (6) @(posedge clk);
  endtask : cap_edge

  initial begin
    repeat (60000) @(posedge clk);
    failCount++;
    $display("unexpected at %0t: watchdog expired", $time);
    finishTest();
  end

  initial begin
    clk = 1'b0; nrst = 1'b0; wbCyc = 1'b0; wbStb = 1'b0; wbWe = 1'b0; wbAdr = '0; wbSel = '0;
    wbDatW = '0; cntPins = '0; capPins = '0; expOvf = '0; seed = 32'hd37da28b; failCount = 0; testsRun = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    for (int t = 0; t < 4; t++) begin
      chk_data(t, 8'h00);
      chk_cnt(t, 8'h00);
      rd_chk(qtu_pkg::IDX_CTL0[t], 4'h0);
      rd_chk(qtu_pkg::IDX_CTL1[t], 4'h0);
      rd_chk(qtu_pkg::IDX_STAT[t], 4'h0);
      wr(qtu_pkg::IDX_CTL0[t], 4'hf);
      rd_chk(qtu_pkg::IDX_CTL0[t], qtu_pkg::CTL0_MASK[t]);
      wr(qtu_pkg::IDX_CTL1[t], 4'hf);
      rd_chk(qtu_pkg::IDX_CTL1[t], 4'h3);
      set_ctl(t, 4'h0, 4'h0);
      wr(qtu_pkg::IDX_STAT[t], 4'hf);
      rd_chk(qtu_pkg::IDX_STAT[t], 4'h0);
    end
    check({28'h0, ovfFlags}, 32'h0);
    rd_chk(8'h00, 4'h0);
    // Counter writes land in data too; unmapped write changes nothing
    for (int i = 0; i < 12; i++) begin
      seed = lfsr_next(seed);
      v = seed[7:0];
      set_cnt(i % 4, v);
      wr(8'h3f, v[3:0]);
      chk_cnt(i % 4, v);
      chk_data(i % 4, v);
    end
    // Auto-reload from ff, data copy of the live count
    for (int t = 0; t < 4; t++) begin
      seed = lfsr_next(seed);
      set_cnt(t, 8'hfd);
      set_ctl(t, 4'h1, 4'h2);
      pulse(2 + t % 2);
      chk_cnt(t, next_count(8'hfd, 8'hfd));
      chk_data(t, 8'hfd);
      wr(qtu_pkg::IDX_DATA_LO[t], seed[3:0]);
      chk_data(t, 8'hfe);
      chk_cnt(t, 8'hfe);
      pulse(2 + t % 2);
      pulse(2 + t % 2);
      expOvf[t] = ~expOvf[t];
      chk_cnt(t, next_count(next_count(8'hfe, 8'hfe), 8'hfe));
      check({28'h0, ovfFlags}, {28'h0, expOvf});
      rd_chk(qtu_pkg::IDX_STAT[t], {3'b000, expOvf[t]});
      set_ctl(t, 4'h0, 4'h2);
      pulse(2 + t % 2);
      chk_cnt(t, 8'hfe);
    end
    // Each clock source counts on timer 0; a pulse on the next source is ignored
    for (int s = 0; s < 3; s++) begin
      set_cnt(0, 8'h10);
      set_ctl(0, 4'h1, s[3:0]);
      pulse(s);
      pulse((s + 1) % 3);
      chk_cnt(0, 8'h11);
    end
    // Frequency mode on timer 0 and timer 2, stopped again afterwards
    for (int t = 0; t < 4; t += 2) begin
      set_cnt(t, 8'h20);
      set_ctl(t, 4'h4, 4'h2);
      pulse(2);
      chk_cnt(t, 8'h21);
      wr(qtu_pkg::IDX_CTL0[t], 4'h0);
    end
    // Capture, blocking while the flag is set, clearing by status read
    for (int t = 0; t < 2; t++) begin
      set_cnt(t, 8'h40);
      set_ctl(t, 4'h3, 4'h2);
      cap_edge(t);
      pulse(2 + t);
      cap_edge(t);
      chk_data(t, 8'h40);
      chk_cnt(t, 8'h41);
      rd_chk(qtu_pkg::IDX_STAT[t], {3'b001, expOvf[t]});
      rd_chk(qtu_pkg::IDX_STAT[t], {3'b000, expOvf[t]});
      cap_edge(t);
      chk_data(t, 8'h41);
      rd_chk(qtu_pkg::IDX_STAT[t], {3'b001, expOvf[t]});
      set_ctl(t, 4'h0, 4'h0);
    end
    // Cascade: low half overflow clocks the high half
    for (int p = 0; p < 2; p++) begin
      set_cnt(2 * p, 8'hff);
      set_cnt(2 * p + 1, 8'h05);
      set_ctl(2 * p + 1, 4'h1, 4'h3);
      wr(qtu_pkg::IDX_CTL1[2 * p], 4'h2);
      pulse(2);
      expOvf[2 * p] = ~expOvf[2 * p];
      check({28'h0, ovfFlags}, {28'h0, expOvf});
      chk_cnt(2 * p, 8'hff);
      chk_cnt(2 * p + 1, 8'h06);
      set_ctl(2 * p + 1, 4'h0, 4'h0);
    end
    // Mid-run reset clears counters, data and overflow bits again
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    chk_cnt(1, 8'h00);
    chk_data(2, 8'h00);
    check({28'h0, ovfFlags}, 32'h0);
    finishTest();
  end
endmodule : qtu_timer_test
